//--- odt_dram_end.sv
// Device-side termination control: timing-mode selection and resistance update.
// Assumes the controller end keeps the pin-level protocol described below.
//
// Behaviour
// - Controller waits mode delay before using pin.
// - Termination runs synchronous or asynchronous timing.
// - No toggling in self refresh or after enable.
// - CKE high or fast exit: synchronous.
// - Slow exit or precharge down: asynchronous.
// - Turn-off before entry: interval decides mode.
// - Turn-on before entry: interval decides mode.
// - Turn-off after any exit: interval decides.
// - Turn-on after slow/precharge exit: interval decides.
// - New resistance applied within mode delay.
// - Resistance held from address bits six, two.
// - Controller waits turn-off before resistance change.
// - Controller holds pin low during update.
// - Controller drives pin definitely in power-down.
// - Termination off through relock after frequency change.
`timescale 1ns/1ps
`default_nettype none
module odt_dram_end #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  odt_link_if.dram link,
  input wire logic bankOpen,
  input wire logic selfRefresh,
  output logic termOn,
  output logic asyncTiming,
  output logic [1:0] termValue,
  output logic updatePending
);

  initial begin
    if (CNT_W < 4 || (1 << CNT_W) <= odt_pkg::MODE_UPDATE_CYC) $error("odt_dram_end: CNT_W too small");
    // The interval counters saturate, so each minimum must sit below the saturation value.
    if ((1 << CNT_W) - 1 <= odt_pkg::PRE_ENTRY_MIN_CYC) $error("odt_dram_end: CNT_W below entry interval");
    if ((1 << CNT_W) - 1 <= odt_pkg::POST_EXIT_MIN_CYC) $error("odt_dram_end: CNT_W below exit interval");
  end

  // ==========================================================================
  // Power-down tracking
  // ==========================================================================
  logic ckePrev_ff;
  logic slowExit_ff;
  logic pdPrecharge_ff;
  logic odtPrev_ff;
  logic [1:0] pendValue_ff;
  logic [CNT_W-1:0] sinceEntry;
  logic [CNT_W-1:0] sinceExit;
  logic [CNT_W-1:0] sinceOdtEdge;
  logic [CNT_W-1:0] updCnt_ff;
  logic pdEntry;
  logic pdExit;
  logic odtEdge;
  logic inPowerDown;
  logic nxt_async;
  logic entryPrecharge;
  logic nearExit;
  logic edgeNearEntry;
  logic entryNearEdge;

  assign pdEntry = ckePrev_ff && !link.cke;
  assign pdExit = !ckePrev_ff && link.cke;
  assign odtEdge = link.odt != odtPrev_ff;
  assign inPowerDown = !link.cke;
  // On the entry edge the latched flavour still holds the previous entry, so the bank state is read directly.
  assign entryPrecharge = pdEntry ? !bankOpen : pdPrecharge_ff;
  // The exit counter restarts only after the exit edge; an edge in that same cycle counts as close.
  assign nearExit = pdExit || sinceExit < CNT_W'(odt_pkg::POST_EXIT_MIN_CYC);
  assign edgeNearEntry = odtEdge && sinceEntry < CNT_W'(odt_pkg::PRE_ENTRY_MIN_CYC);
  assign entryNearEdge = pdEntry && sinceOdtEdge < CNT_W'(odt_pkg::PRE_ENTRY_MIN_CYC);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ckePrev_ff <= 1'b0;
      odtPrev_ff <= 1'b0;
    end else begin
      ckePrev_ff <= link.cke;
      odtPrev_ff <= link.odt;
    end
  end

  // The flavour of power-down is frozen at entry, since the bank state is what counts then.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pdPrecharge_ff <= 1'b1;
    end else if (pdEntry) begin
      pdPrecharge_ff <= !bankOpen;
    end
  end

  odt_interval_counter #(.WIDTH(CNT_W)) entryCnt (
    .clk(clk), .resetn(resetn), .restart(pdEntry), .count(sinceEntry));
  odt_interval_counter #(.WIDTH(CNT_W)) exitCnt (
    .clk(clk), .resetn(resetn), .restart(pdExit), .count(sinceExit));
  odt_interval_counter #(.WIDTH(CNT_W)) edgeCnt (
    .clk(clk), .resetn(resetn), .restart(odtEdge), .count(sinceOdtEdge));

  // ==========================================================================
  // Timing-mode selection
  // ==========================================================================
  // Slow-exit active and precharge power-down both use the asynchronous delays.
  function automatic logic async_flavour(input logic slowExit, input logic precharge);
    return slowExit || precharge;
  endfunction : async_flavour

  always_comb begin
    nxt_async = 1'b0;
    if (inPowerDown) begin
      if (async_flavour(slowExit_ff, entryPrecharge)) begin
        nxt_async = 1'b1;
      end
      // An edge too close before or after entry falls back to asynchronous delays.
      if (edgeNearEntry || entryNearEdge) begin
        nxt_async = 1'b1;
      end
    end else if (odtEdge && nearExit) begin
      if (!link.odt) begin
        nxt_async = 1'b1;
      end else if (async_flavour(slowExit_ff, pdPrecharge_ff)) begin
        nxt_async = 1'b1;
      end
    end
  end

  // The selected mode holds between events, so a user reads it as the mode of the last transition.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      asyncTiming <= 1'b0;
    end else if (odtEdge || pdEntry || pdExit) begin
      asyncTiming <= nxt_async;
    end
  end

  // Termination follows the pin except in self refresh, where it is unavailable, and while the resistance is set to off.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      termOn <= 1'b0;
    end else begin
      termOn <= link.odt && !selfRefresh && termValue != odt_pkg::RES_OFF;
    end
  end

  // ==========================================================================
  // Mode register loads and resistance update
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slowExit_ff <= 1'b0;
    end else if (link.cmd == odt_pkg::CMD_LOAD_MODE) begin
      slowExit_ff <= link.addr[odt_pkg::SLOW_EXIT_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendValue_ff <= odt_pkg::RES_OFF;
      updCnt_ff <= '0;
    end else if (link.cmd == odt_pkg::CMD_EXT_MODE_SET) begin
      pendValue_ff <= {link.addr[odt_pkg::RES_HI_BIT], link.addr[odt_pkg::RES_LO_BIT]};
      updCnt_ff <= CNT_W'(odt_pkg::MODE_UPDATE_CYC);
    end else if (updCnt_ff != '0) begin
      updCnt_ff <= updCnt_ff - 1'b1;
    end
  end

  // The new value lands when the update count expires, within the mode delay.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      termValue <= odt_pkg::RES_OFF;
      updatePending <= 1'b0;
    end else begin
      updatePending <= updCnt_ff > CNT_W'(1) || link.cmd == odt_pkg::CMD_EXT_MODE_SET;
      if (updCnt_ff == CNT_W'(1)) begin
        termValue <= pendValue_ff;
      end
    end
  end

endmodule : odt_dram_end
`default_nettype wire

//--- odt_pkg.sv
// Shared constants for the termination timing selector and its controller.
// Assumes a single 125 MHz memory clock shared by both ends.
package odt_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MODE_UPDATE_NS = 12;
  // Least time, rounded up to whole cycles.
  localparam int MODE_UPDATE_CYC = (MODE_UPDATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELOCK_CYC = 200;
  localparam int PRE_ENTRY_MIN_CYC = 3;
  localparam int POST_EXIT_MIN_CYC = 3;
  localparam int SYNC_OFF_CYC = 3;
  localparam int ENABLE_SETTLE_CYC = 4;
  localparam int CKE_MIN_CYC = 3;

  // ==========================================================================
  // Mode register fields
  // ==========================================================================
  localparam int SLOW_EXIT_BIT = 12;
  localparam int RES_HI_BIT = 6;
  localparam int RES_LO_BIT = 2;
  localparam logic [1:0] RES_OFF = 2'h0;

  // ==========================================================================
  // Commands
  // ==========================================================================
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACTIVATE = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_REFRESH = 3'h3,
    CMD_LOAD_MODE = 3'h4,
    CMD_EXT_MODE_SET = 3'h5
  } cmd_e;

endpackage : odt_pkg

//--- odt_link_if.sv
// Pins between the memory controller and the termination logic.
// Assumes both ends share clk; the testbench instantiates and joins them.
`timescale 1ns/1ps
`default_nettype none
interface odt_link_if;
  logic odt;
  logic cke;
  odt_pkg::cmd_e cmd;
  logic [13:0] addr;

  modport ctrl (output odt, output cke, output cmd, output addr);
  modport dram (input odt, input cke, input cmd, input addr);
endinterface : odt_link_if
`default_nettype wire

//--- odt_interval_counter.sv
// Saturating counter of clocks since a restart pulse.
// Assumes restart is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module odt_interval_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  output logic [WIDTH-1:0] count
);

  initial begin
    if (WIDTH < 2) $error("odt_interval_counter: WIDTH too small");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '1;
    end else if (restart) begin
      count <= '0;
    end else if (count != '1) begin
      count <= count + 1'b1;
    end
  end

endmodule : odt_interval_counter
`default_nettype wire

//--- odt_ctrl_end.sv
// Controller-side end: drives termination pin, clock enable and mode loads.
// Assumes user requests are level/pulse inputs in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module odt_ctrl_end #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  odt_link_if.ctrl link,
  input wire logic wantTerm,
  input wire logic wantPowerDown,
  input wire logic selfRefresh,
  input wire logic freqChange,
  input wire logic setValid,
  input wire logic [1:0] setValue,
  output logic setBusy
);

  initial begin
    if ((1 << CNT_W) <= odt_pkg::RELOCK_CYC) $error("odt_ctrl_end: CNT_W too small");
  end

  // ==========================================================================
  // Hold-off timer: blocks the termination pin after loads and relock.
  // ==========================================================================
  logic [CNT_W-1:0] holdCnt_ff;
  logic [CNT_W-1:0] offCnt_ff;
  logic [CNT_W-1:0] ckeCnt_ff;
  logic pendSet_ff;
  logic issueSet;

  // A resistance change waits until the pin has been low long enough to settle.
  assign issueSet = pendSet_ff && !link.odt && offCnt_ff >= CNT_W'(odt_pkg::SYNC_OFF_CYC)
                    && link.cke && holdCnt_ff == '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdCnt_ff <= '0;
    end else if (issueSet) begin
      holdCnt_ff <= CNT_W'(odt_pkg::MODE_UPDATE_CYC + odt_pkg::ENABLE_SETTLE_CYC);
    end else if (freqChange && !link.cke) begin
      holdCnt_ff <= CNT_W'(odt_pkg::RELOCK_CYC);
    end else if (holdCnt_ff != '0 && link.cke) begin
      holdCnt_ff <= holdCnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendSet_ff <= 1'b0;
    end else if (setValid) begin
      pendSet_ff <= 1'b1;
    end else if (issueSet) begin
      pendSet_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      offCnt_ff <= '0;
    end else if (link.odt) begin
      offCnt_ff <= '0;
    end else if (offCnt_ff != '1) begin
      offCnt_ff <= offCnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // The pin is always a definite level; it never floats, even in power-down.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.odt <= 1'b0;
    end else begin
      link.odt <= wantTerm && !selfRefresh && !pendSet_ff && holdCnt_ff == '0 && !freqChange;
    end
  end

  // Clock enable changes only after its minimum hold of a few cycles.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.cke <= 1'b0;
      ckeCnt_ff <= '0;
    end else if (link.cke == wantPowerDown && ckeCnt_ff >= CNT_W'(odt_pkg::CKE_MIN_CYC)) begin
      link.cke <= !wantPowerDown;
      ckeCnt_ff <= '0;
    end else if (ckeCnt_ff != '1) begin
      ckeCnt_ff <= ckeCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.cmd <= odt_pkg::CMD_NOP;
      link.addr <= '0;
    end else if (issueSet) begin
      link.cmd <= odt_pkg::CMD_EXT_MODE_SET;
      link.addr <= '0;
      link.addr[odt_pkg::RES_HI_BIT] <= setValue[1];
      link.addr[odt_pkg::RES_LO_BIT] <= setValue[0];
    end else begin
      link.cmd <= odt_pkg::CMD_NOP;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setBusy <= 1'b0;
    end else begin
      setBusy <= setValid || pendSet_ff || holdCnt_ff != '0;
    end
  end

endmodule : odt_ctrl_end
`default_nettype wire

//--- odt_link_assertions.sv
// Assertions on the pins that join the controller end to the device end.
// Assumes one clock and that the signals come straight from the interface.
`timescale 1ns/1ps
`default_nettype none
module odt_link_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic odt,
  input wire logic cke,
  input wire odt_pkg::cmd_e cmd
);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic isSet = (cmd == odt_pkg::CMD_EXT_MODE_SET);
  sequence quietPin3;
    !odt [*3];
  endsequence
  sequence quietPin5;
    !odt [*5];
  endsequence

  // ==========================================================================
  // Properties
  // ==========================================================================
  turnoff_before_set_a: assert property (isSet |-> !$past(odt, 1) && !$past(odt, 2) && !$past(odt, 3))
    else $error("termination pin was high too close before a resistance change");
  pin_low_update_a: assert property (isSet |-> quietPin3)
    else $error("termination pin rose inside the update window");
  settle_after_set_a: assert property (isSet |-> quietPin5)
    else $error("termination pin toggled while the new setting settles");
  set_one_cycle_a: assert property (isSet |=> !isSet)
    else $error("mode set command stood longer than one cycle");
  set_needs_cke_a: assert property (isSet |-> cke && $past(cke))
    else $error("mode set command issued outside normal operation");
  cke_low_min_a: assert property ($fell(cke) |=> !cke [*3])
    else $error("clock enable low for too short a time");
  cke_high_min_a: assert property ($rose(cke) |=> cke [*3])
    else $error("clock enable high for too short a time");
  pd_edge_nop_a: assert property ($changed(cke) |-> cmd == odt_pkg::CMD_NOP)
    else $error("power-down entry or exit carried a command");
endmodule : odt_link_assertions
`default_nettype wire

//--- test_ddr2_odt_timing_select.sv
// Self-checking bench: both ends joined by the link interface.
// Assumes the package, interface and both end modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_ddr2_odt_timing_select;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wantTerm = 1'b0;
  logic wantPowerDown = 1'b0;
  logic selfRefresh = 1'b0;
  logic freqChange = 1'b0;
  logic setValid = 1'b0;
  logic [1:0] setValue = 2'h0;
  logic bankOpen = 1'b0;
  logic setBusy, termOn, asyncTiming, updatePending;
  logic [1:0] termValue;
  int nMismatch = 0;
  int totalChecks = 0;
  int cycles = 0;

  odt_link_if link ();
  odt_ctrl_end u_odt_ctrl_end (.clk(clk), .resetn(resetn), .link(link), .wantTerm(wantTerm),
    .wantPowerDown(wantPowerDown), .selfRefresh(selfRefresh), .freqChange(freqChange),
    .setValid(setValid), .setValue(setValue), .setBusy(setBusy));
  odt_dram_end u_odt_dram_end (.clk(clk), .resetn(resetn), .link(link), .bankOpen(bankOpen),
    .selfRefresh(selfRefresh), .termOn(termOn), .asyncTiming(asyncTiming), .termValue(termValue),
    .updatePending(updatePending));
  odt_link_assertions u_odt_link_assertions (.clk(clk), .resetn(resetn), .odt(link.odt),
    .cke(link.cke), .cmd(link.cmd));

  // ==========================================================================
  // Clock, timeout and reporting
  // ==========================================================================
  initial begin
    forever #4 clk = ~clk;
  end

  // The whole run needs under a thousand cycles; three thousand leaves margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nMismatch++;
      close_out();
    end
  end

  task automatic close_out();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    totalChecks++;
    if (seen !== want) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, want);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic set_value(input logic [1:0] v);
    int k;
    @(posedge clk) begin
      setValid <= 1'b1;
      setValue <= v;
    end
    @(posedge clk) setValid <= 1'b0;
    #1;
    for (k = 0; k < 40 && link.cmd !== odt_pkg::CMD_EXT_MODE_SET; k++) tick(1);
    check({link.addr[6], link.addr[2]}, v);
    check(link.odt, 1'b0);
    tick(1);
    check(updatePending, 1'b1);
    tick(3);
    check(termValue, v);
    check(updatePending, 1'b0);
    for (k = 0; k < 40 && setBusy !== 1'b0; k++) tick(1);
  endtask : set_value

  // Toggling the pin right at exit must fall inside the post-exit interval.
  task automatic power_down(input logic bank, input logic want);
    logic toggled;
    toggled = want ^ wantTerm;
    @(posedge clk) begin
      bankOpen <= bank;
      wantPowerDown <= 1'b1;
    end
    tick(12);
    check(link.cke, 1'b0);
    check(asyncTiming, !bank);
    @(posedge clk) begin
      wantPowerDown <= 1'b0;
      wantTerm <= want;
    end
    tick(12);
    check(asyncTiming, toggled);
  endtask : power_down

  task automatic self_refresh();
    @(posedge clk) selfRefresh <= 1'b1;
    tick(6);
    check({link.odt, termOn}, 2'h0);
    @(posedge clk) selfRefresh <= 1'b0;
    tick(10);
    check(termOn, 1'b1);
  endtask : self_refresh

  task automatic freq_change();
    logic lateOn;
    lateOn = 1'b0;
    @(posedge clk) wantPowerDown <= 1'b1;
    tick(10);
    @(posedge clk) freqChange <= 1'b1;
    tick(4);
    @(posedge clk) begin
      wantPowerDown <= 1'b0;
      freqChange <= 1'b0;
    end
    repeat (190) begin
      tick(1);
      lateOn = lateOn | link.odt;
    end
    check(lateOn, 1'b0);
    tick(30);
    check(link.odt, 1'b1);
  endtask : freq_change

  initial begin
    repeat (10) @(posedge clk);
    #1;
    check({termOn, asyncTiming, termValue, updatePending, setBusy, link.cke, link.odt}, 8'h00);
    @(posedge clk) resetn <= 1'b1;
    @(posedge clk) wantTerm <= 1'b1;
    tick(8);
    check(termOn, 1'b0);
    for (int i = 1; i < 6; i++) set_value(2'(i));
    tick(8);
    check({termOn, asyncTiming}, 2'h2);
    power_down(1'b1, 1'b1);
    power_down(1'b0, 1'b0);
    power_down(1'b0, 1'b1);
    self_refresh();
    freq_change();
    close_out();
  end
endmodule : test_ddr2_odt_timing_select
`default_nettype wire
